// ===== hdl/scb_defines.svh
// Purpose: offsets, field positions, reset values and timing counts of the serial channel
// Assumes: register port with a 3-bit word address
// Notes: definitions only
`ifndef SCB_DEFINES_SVH
`define SCB_DEFINES_SVH

// register word addresses
`define SCB_ADDR_FORMAT     3'h0
`define SCB_ADDR_DIVISOR    3'h1
`define SCB_ADDR_CONTROL    3'h2
`define SCB_ADDR_TXBUF      3'h3
`define SCB_ADDR_STATUS     3'h4
`define SCB_ADDR_RXBUF      3'h5

// serial_format fields
`define SCB_FMT_SYNC        7
`define SCB_FMT_SEVEN       6
`define SCB_FMT_PAR_EN      5
`define SCB_FMT_PAR_ODD     4
`define SCB_FMT_TWO_STOP    3
`define SCB_FMT_MULTIPROC   2

// serial_control fields
`define SCB_CTL_TX_EN       5
`define SCB_CTL_RX_EN       4

// serial_status_flags fields
`define SCB_ST_TX_EMPTY     7
`define SCB_ST_RX_FULL      6
`define SCB_ST_OVERRUN      5
`define SCB_ST_FRAME_ERR    4
`define SCB_ST_PARITY_ERR   3
`define SCB_ST_TX_END       2
`define SCB_ST_MPB_RX       1
`define SCB_ST_MPB_TX       0

// reset values
`define SCB_RST_RXBUF       8'h00
`define SCB_RST_TXBUF       8'hFF
`define SCB_RST_FORMAT      8'h00
`define SCB_RST_DIVISOR     8'hFF
`define SCB_RST_CONTROL     8'h00

// timing: baud ticks per bit, sample points within a bit
`define SCB_TICK_LAST       4'hF
`define SCB_TICK_MID        4'h7
`define SCB_SYNC_HIGH_BIT   3

`endif

// ===== hdl/scb_pkg.sv
// Purpose: types of the serial channel
// Assumes: nothing
// Notes: state of the channel is one packed struct
package scb_pkg;

    typedef enum logic [2:0] {
        PH_IDLE   = 3'b000,
        PH_START  = 3'b001,
        PH_DATA   = 3'b011,
        PH_PARITY = 3'b010,
        PH_STOP   = 3'b110
    } scb_phase_e;

    typedef struct packed {
        logic [7:0] serialFormat;
        logic [7:0] bitRateDivisor;
        logic [7:0] serialControl;
        logic [7:0] transmitBuffer;
        logic [7:0] receiveBuffer;
        logic [7:0] readData;
        logic       txBufferEmptyFlag;
        logic       rxBufferFullFlag;
        logic       overrunFlag;
        logic       frameErrFlag;
        logic       parityErrFlag;
        logic       txEndFlag;
        logic       mpbRx;
        logic       mpbTx;
        logic [5:0] prescaleCount;
        logic [7:0] baudCount;
        scb_phase_e txPhase;
        logic [7:0] transmitShifter;
        logic [3:0] txTick;
        logic [2:0] txBit;
        logic       txPar;
        logic       txSecondStop;
        logic       txLine;
        logic       serialClockLine;
        scb_phase_e rxPhase;
        logic [7:0] receiveShifter;
        logic [3:0] rxTick;
        logic [2:0] rxBit;
        logic       rxParBad;
    } scb_state_s;

endpackage

// ===== hdl/scb_serial_channel.sv
// Purpose: data path and frame format of one serial channel
// Assumes: inputs synchronous to clock; reset wins over clockEnable
// Notes: baud tick = clock / 4^n / (divisor+1); one bit is 16 ticks in both modes
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`include "scb_defines.svh"
`default_nettype none

module scb_serial_channel
    import scb_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic       clockEnable,
    // register port
    input  wire logic [2:0] regAddr,
    input  wire logic [7:0] regWriteData,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic      [7:0] regReadData,
    // serial lines
    input  wire logic       receiveLine,
    output logic            transmitLine,
    output logic            serialClockOut
);

    scb_state_s s;
    scb_state_s n;
    logic       tick;
    logic       txBitEnd;
    logic       txFrameEnd;
    logic       rxSample;
    logic       rxFrameEnd;
    logic       syncMode;
    logic       sevenBits;
    logic       parityOn;
    logic       multiOn;
    logic [2:0] lastBit;
    function automatic logic [5:0] prescaleLimit(input logic [1:0] sel);
        unique case (sel)
            2'b00: prescaleLimit = 6'h00;
            2'b01: prescaleLimit = 6'h03;
            2'b10: prescaleLimit = 6'h0F;
            2'b11: prescaleLimit = 6'h3F;
        endcase
    endfunction
    function automatic logic [7:0] charData(input logic [7:0] raw, input logic seven);
        charData = seven ? {1'b0, raw[6:0]} : raw;
    endfunction
    assign regReadData    = s.readData;
    assign transmitLine   = s.txLine;
    assign serialClockOut = s.serialClockLine;
    always_comb begin
        n          = s;
        txFrameEnd = 1'b0;
        rxFrameEnd = 1'b0;
        syncMode   = s.serialFormat[`SCB_FMT_SYNC];
        sevenBits  = !syncMode && s.serialFormat[`SCB_FMT_SEVEN];
        multiOn    = !syncMode && s.serialFormat[`SCB_FMT_MULTIPROC];
        parityOn   = !syncMode && !multiOn && s.serialFormat[`SCB_FMT_PAR_EN];
        lastBit    = sevenBits ? 3'd6 : 3'd7;
        // baud generator
        tick = (s.prescaleCount == prescaleLimit(s.serialFormat[1:0]))
            && (s.baudCount == s.bitRateDivisor);
        if (s.prescaleCount == prescaleLimit(s.serialFormat[1:0])) begin
            n.prescaleCount = 6'h00;
            n.baudCount     = tick ? 8'h00 : s.baudCount + 8'h01;
        end else begin
            n.prescaleCount = s.prescaleCount + 6'h01;
        end
        // register port; shifters are not decoded here
        n.readData = 8'h00;
        if (regRead) begin
            unique case (regAddr)
                `SCB_ADDR_FORMAT:  n.readData = s.serialFormat;
                `SCB_ADDR_DIVISOR: n.readData = s.bitRateDivisor;
                `SCB_ADDR_CONTROL: n.readData = s.serialControl;
                `SCB_ADDR_TXBUF:   n.readData = s.transmitBuffer;
                `SCB_ADDR_STATUS:  n.readData = {s.txBufferEmptyFlag, s.rxBufferFullFlag,
                                                 s.overrunFlag, s.frameErrFlag,
                                                 s.parityErrFlag, s.txEndFlag,
                                                 s.mpbRx, s.mpbTx};
                `SCB_ADDR_RXBUF:   n.readData = s.receiveBuffer;
                default:           n.readData = 8'h00;
            endcase
        end
        if (regWrite) begin
            unique case (regAddr)
                `SCB_ADDR_FORMAT:  n.serialFormat   = regWriteData;
                `SCB_ADDR_DIVISOR: n.bitRateDivisor = regWriteData;
                `SCB_ADDR_CONTROL: n.serialControl  = regWriteData;
                `SCB_ADDR_TXBUF:   n.transmitBuffer = regWriteData;
                `SCB_ADDR_STATUS: begin
                    // a one written leaves a flag alone, a zero clears it; mpbTx takes the written bit, mpbRx is not written
                    n.txBufferEmptyFlag = s.txBufferEmptyFlag & regWriteData[`SCB_ST_TX_EMPTY];
                    n.rxBufferFullFlag  = s.rxBufferFullFlag & regWriteData[`SCB_ST_RX_FULL];
                    n.overrunFlag       = s.overrunFlag & regWriteData[`SCB_ST_OVERRUN];
                    n.frameErrFlag      = s.frameErrFlag & regWriteData[`SCB_ST_FRAME_ERR];
                    n.parityErrFlag     = s.parityErrFlag & regWriteData[`SCB_ST_PARITY_ERR];
                    n.txEndFlag         = s.txEndFlag & regWriteData[`SCB_ST_TX_END];
                    n.mpbTx             = regWriteData[`SCB_ST_MPB_TX];
                end
                default: ;
            endcase
        end
        // transmitter; flag sets below come after the writes so a set wins
        txBitEnd = tick && (s.txTick == `SCB_TICK_LAST);
        if (tick && s.txPhase != PH_IDLE) begin
            n.txTick = s.txTick + 4'h1;
        end
        if (!s.serialControl[`SCB_CTL_TX_EN]) begin
            n.txPhase = PH_IDLE;
        end else begin
            unique case (s.txPhase)
                PH_IDLE: ;
                PH_START: begin
                    if (txBitEnd) begin
                        n.txPhase = PH_DATA;
                    end
                end
                PH_DATA: begin
                    if (txBitEnd) begin
                        n.transmitShifter = {1'b1, s.transmitShifter[7:1]};
                        n.txBit           = s.txBit + 3'd1;
                        if (s.txBit == lastBit) begin
                            if (syncMode) begin
                                txFrameEnd = 1'b1;
                            end else if (parityOn || multiOn) begin
                                n.txPhase = PH_PARITY;
                            end else begin
                                n.txPhase      = PH_STOP;
                                n.txSecondStop = s.serialFormat[`SCB_FMT_TWO_STOP];
                            end
                        end
                    end
                end
                PH_PARITY: begin
                    if (txBitEnd) begin
                        n.txPhase      = PH_STOP;
                        n.txSecondStop = s.serialFormat[`SCB_FMT_TWO_STOP];
                    end
                end
                PH_STOP: begin
                    if (txBitEnd) begin
                        n.txSecondStop = 1'b0;
                        txFrameEnd     = !s.txSecondStop;
                    end
                end
                default: n.txPhase = PH_IDLE;
            endcase
        end
        if (txFrameEnd) begin
            n.txPhase   = PH_IDLE;
            n.txEndFlag = 1'b1;
        end
        // idle or frame end: take a pending byte with no gap
        if (s.serialControl[`SCB_CTL_TX_EN] && n.txPhase == PH_IDLE
                && !s.txBufferEmptyFlag) begin
            n.transmitShifter   = s.transmitBuffer;
            n.txBufferEmptyFlag = 1'b1;
            n.txEndFlag         = 1'b0;
            n.txTick            = 4'h0;
            n.txBit             = 3'd0;
            n.txPar             = multiOn ? s.mpbTx
                                : ^charData(s.transmitBuffer, sevenBits)
                                  ^ s.serialFormat[`SCB_FMT_PAR_ODD];
            n.txPhase           = syncMode ? PH_DATA : PH_START;
        end
        unique case (n.txPhase)
            PH_START:  n.txLine = 1'b0;
            PH_DATA:   n.txLine = n.transmitShifter[0];
            PH_PARITY: n.txLine = n.txPar;
            default:   n.txLine = 1'b1;
        endcase
        // receiver
        rxSample = tick && (s.rxTick == ((syncMode || s.rxPhase == PH_START)
                                         ? `SCB_TICK_MID : `SCB_TICK_LAST));
        if (tick && s.rxPhase != PH_IDLE) begin
            n.rxTick = s.rxTick + 4'h1;
        end
        if (!s.serialControl[`SCB_CTL_RX_EN]) begin
            n.rxPhase = PH_IDLE;
        end else begin
            unique case (s.rxPhase)
                PH_IDLE: begin
                    if (syncMode || !receiveLine) begin
                        n.rxPhase  = syncMode ? PH_DATA : PH_START;
                        n.rxTick   = 4'h0;
                        n.rxBit    = 3'd0;
                        n.rxParBad = 1'b0;
                    end
                end
                PH_START: begin
                    if (rxSample) begin
                        // a glitch shorter than half a bit is not a start
                        n.rxPhase = receiveLine ? PH_IDLE : PH_DATA;
                        n.rxTick  = 4'h0;
                    end
                end
                PH_DATA: begin
                    if (rxSample) begin
                        n.receiveShifter = {receiveLine, s.receiveShifter[7:1]};
                        n.rxBit          = s.rxBit + 3'd1;
                        if (s.rxBit == lastBit) begin
                            if (syncMode) begin
                                rxFrameEnd = 1'b1;
                            end else if (parityOn || multiOn) begin
                                n.rxPhase = PH_PARITY;
                            end else begin
                                n.rxPhase = PH_STOP;
                            end
                        end
                    end
                end
                PH_PARITY: begin
                    if (rxSample) begin
                        n.rxPhase  = PH_STOP;
                        n.rxParBad = parityOn && ((^charData(s.receiveShifter >> sevenBits,
                                     sevenBits) ^ receiveLine)
                                     != s.serialFormat[`SCB_FMT_PAR_ODD]);
                        if (multiOn) begin
                            n.mpbRx = receiveLine;
                        end
                    end
                end
                PH_STOP: begin
                    rxFrameEnd = rxSample;
                end
                default: n.rxPhase = PH_IDLE;
            endcase
        end
        if (rxFrameEnd) begin
            // back to idle at once so a low second stop counts as a start
            n.rxPhase = PH_IDLE;
            if (s.rxBufferFullFlag) begin
                n.overrunFlag = 1'b1;
            end else begin
                n.receiveBuffer    = charData(n.receiveShifter >> sevenBits,
                                              sevenBits);
                n.rxBufferFullFlag = 1'b1;
                n.frameErrFlag     = n.frameErrFlag
                                   | (s.rxPhase == PH_STOP && !receiveLine);
                n.parityErrFlag    = n.parityErrFlag | n.rxParBad;
            end
        end
        // synchronous clock low in the first half of each bit
        n.serialClockLine = !(syncMode
            && ((n.txPhase != PH_IDLE && !n.txTick[`SCB_SYNC_HIGH_BIT])
             || (n.txPhase == PH_IDLE && n.rxPhase != PH_IDLE
                 && !n.rxTick[`SCB_SYNC_HIGH_BIT])));
        if (reset) begin
            n                   = '0;
            n.serialFormat      = `SCB_RST_FORMAT;
            n.bitRateDivisor    = `SCB_RST_DIVISOR;
            n.serialControl     = `SCB_RST_CONTROL;
            n.transmitBuffer    = `SCB_RST_TXBUF;
            n.receiveBuffer     = `SCB_RST_RXBUF;
            n.txBufferEmptyFlag = 1'b1;
            n.txEndFlag         = 1'b1;
            n.txLine            = 1'b1;
            n.serialClockLine   = 1'b1;
        end
    end
    // reset acts even with the clock enable low
    always_ff @(posedge clock) begin
        if (reset || clockEnable) begin
            s <= n;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    property p_rxbuf_reset;
        disable iff (1'b0) reset |=> (s.receiveBuffer == 8'h00) && !s.rxBufferFullFlag;
    endproperty
    a_rxbuf_reset: assert property (p_rxbuf_reset) else $error("receive buffer not zero");
    property p_txbuf_reset;
        disable iff (1'b0) reset |=> (s.transmitBuffer == 8'hFF) && s.txBufferEmptyFlag;
    endproperty
    a_txbuf_reset: assert property (p_txbuf_reset) else $error("transmit reset wrong");
    property p_full_from_receiver;
        $rose(s.rxBufferFullFlag) |-> $past(s.rxPhase) != PH_IDLE;
    endproperty
    a_full_from_receiver: assert property (p_full_from_receiver)
        else $error("full flag set without a frame");
    property p_rx_done_idle;
        (clockEnable && rxFrameEnd && !s.rxBufferFullFlag) |=>
            s.rxPhase == PH_IDLE && s.rxBufferFullFlag;
    endproperty
    a_rx_done_idle: assert property (p_rx_done_idle) else $error("receiver not rearmed");
    property p_tx_load;
        (clockEnable && s.txPhase == PH_IDLE && !s.txBufferEmptyFlag
            && s.serialControl[`SCB_CTL_TX_EN]) |=>
            s.txPhase != PH_IDLE && s.txBufferEmptyFlag;
    endproperty
    a_tx_load: assert property (p_tx_load) else $error("pending byte not loaded");
    property p_lsb_first;
        (clockEnable && s.txPhase == PH_START && txBitEnd) |=>
            transmitLine == $past(s.transmitShifter[0]);
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("first data bit not lsb");
    property p_sync_no_start;
        s.serialFormat[`SCB_FMT_SYNC] && s.txPhase == PH_IDLE |=> s.txPhase != PH_START;
    endproperty
    a_sync_no_start: assert property (p_sync_no_start) else $error("start bit in sync");
    property p_start_low;
        s.txPhase == PH_START |-> transmitLine == 1'b0 ##0 s.txEndFlag == 1'b0;
    endproperty
    a_start_low: assert property (p_start_low) else $error("start bit not low");

endmodule

`default_nettype wire

// ===== dv/scb_remote_model.sv
// Purpose: remote serial device facing the channel's receive and transmit lines
// Assumes: bit length in clock cycles and frame length are set by the bench
// Notes: captures async frames from the first low sample; captures sync bits on clock rise
`timescale 1ns/1ns
`default_nettype none

module scb_remote_model (
    // clock
    input  wire logic        clock,
    // lines from the channel
    input  wire logic        transmitLine,
    input  wire logic        serialClockOut,
    // frame shape
    input  wire logic [31:0] frameBits,
    input  wire logic [31:0] bitLen,
    // line into the channel
    output logic             receiveLine
);
    logic [11:0] capQ[$];
    int          startQ[$];
    int          cyc = 0;
    logic [7:0]  syncBits = '0;
    int          syncCount = 0;
    logic        lastClk = 1'b1;

    initial receiveLine = 1'b1;

    always @(posedge clock) begin
        cyc <= cyc + 1;
        lastClk <= serialClockOut;
        if (serialClockOut && !lastClk) begin
            syncBits <= {transmitLine, syncBits[7:1]};
            syncCount <= syncCount + 1;
        end
    end

    // mid-bit sampling; start seen up to one cycle late, same for every frame
    initial forever begin
        logic [11:0] v;
        int          t;
        @(posedge clock);
        if (transmitLine === 1'b0) begin
            t = cyc;
            v = '1;
            v[0] = 1'b0;
            repeat (bitLen / 2) @(posedge clock);
            for (int i = 1; i < frameBits; i++) begin
                repeat (bitLen) @(posedge clock);
                v[i] = transmitLine;
            end
            capQ.push_back(v);
            startQ.push_back(t);
        end
    end

    // idle level high between frames, as a real line would rest
    task automatic send_frame(input logic [11:0] v, input int n);
        @(posedge clock);
        for (int i = 0; i < n; i++) begin
            receiveLine <= v[i];
            repeat (bitLen) @(posedge clock);
        end
        receiveLine <= 1'b1;
    endtask
endmodule

`default_nettype wire

// ===== dv/tb.sv
// Purpose: self-checking bench of the serial channel
// Assumes: divisor 0 so one tick per prescaled clock, 16 ticks per bit
// Notes: expected frames are built here from the format bits
`timescale 1ns/1ns
`default_nettype none

module tb;
    import scb_pkg::*;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        regWrite = 1'b0;
    logic        regRead = 1'b0;
    logic [2:0]  regAddr = '0;
    logic [7:0]  regWriteData = '0;
    logic [7:0]  regReadData, rdv;
    logic        receiveLine, transmitLine, serialClockOut;
    logic [31:0] frameBits = 32'd10;
    logic [31:0] bitLen = 32'd16;
    int          n_errors = 0;
    int          cmp_count = 0;
    logic [7:0]  fmts [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h40, 8'h20, 8'h30, 8'h08,
                               8'h24, 8'h34, 8'h78};

    always #10 clock = ~clock;

    scb_serial_channel scb_serial_channel_i (.clock(clock), .reset(reset), .clockEnable(1'b1),
        .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
        .regReadData(regReadData), .receiveLine(receiveLine), .transmitLine(transmitLine),
        .serialClockOut(serialClockOut));
    scb_remote_model scb_remote_model_i (.clock(clock), .transmitLine(transmitLine),
        .serialClockOut(serialClockOut), .frameBits(frameBits), .bitLen(bitLen),
        .receiveLine(receiveLine));

    task automatic complete_run;
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        regWrite <= 1'b1;
        regAddr <= a;
        regWriteData <= d;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a);
        @(posedge clock);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRead <= 1'b0;
        #1 rdv = regReadData;
    endtask

    task automatic wait_flag(input int b);
        for (int k = 0; k < 3000; k++) begin
            rd(3'h4);
            if (rdv[b] === 1'b1) return;
        end
        check("flag", rdv[b], 1);
    endtask

    // frame as sent: start, data lsb first, parity or multiproc bit, stops
    function automatic int build(input logic [7:0] f, input logic [7:0] d, output logic [11:0] v);
        int   n;
        logic x;
        n = f[6] ? 7 : 8;
        x = f[4];
        v = '1;
        v[0] = 1'b0;
        for (int i = 0; i < n; i++) begin
            v[i + 1] = d[i];
            x ^= d[i];
        end
        if (f[2]) begin
            v[n + 1] = 1'b1;
            n++;
        end else if (f[5]) begin
            v[n + 1] = x;
            n++;
        end
        return n + 2 + int'(f[3]);
    endfunction

    task automatic reset_values;
        rd(3'h5);
        check("rxbuf", rdv, 8'h00);
        rd(3'h3);
        check("txbuf", rdv, 8'hFF);
        rd(3'h4);
        check("status", rdv, 8'h84);
        wr(3'h5, 8'h55);
        rd(3'h5);
        check("rxbuf write", rdv, 8'h00);
        rd(3'h6);
        check("unmapped", rdv, 8'h00);
        wr(3'h4, 8'hFF);
        rd(3'h4);
        check("status set", rdv, 8'h85);
        wr(3'h1, 8'h00);
        // baud counter may sit above the new divisor and must wrap first
        repeat (256) @(posedge clock);
        wr(3'h2, 8'h30);
    endtask

    // second stop slot carries the next start
    task automatic rx_double;
        logic [11:0] v0, v1;
        int          len;
        wr(3'h0, 8'h08);
        len = build(8'h08, 8'h3C, v0);
        void'(build(8'h08, 8'hC3, v1));
        fork
            begin
                scb_remote_model_i.send_frame(v0, len - 1);
                scb_remote_model_i.send_frame(v1, len - 1);
            end
        join_none
        wait_flag(6);
        rd(3'h5);
        check("rx first", rdv, 8'h3C);
        wr(3'h4, 8'hBF);
        wait_flag(6);
        rd(3'h5);
        check("rx second", rdv, 8'hC3);
        rd(3'h4);
        check("rx errors", rdv[5:4], 2'b00);
        wr(3'h4, 8'h81);
    endtask

    task automatic rx_parity;
        logic [11:0] v;
        int          len;
        wr(3'h0, 8'h20);
        len = build(8'h20, 8'h01, v);
        v[9] = ~v[9];
        scb_remote_model_i.send_frame(v, len);
        wait_flag(6);
        rd(3'h4);
        check("parity err", rdv[3], 1'b1);
        rd(3'h5);
        check("rx parity data", rdv, 8'h01);
        wr(3'h4, 8'h81);
    endtask

    task automatic tx_pair(input logic [7:0] f, input logic [7:0] b0, input logic [7:0] b1);
        logic [11:0] v0, v1;
        int          len, p;
        wr(3'h0, f);
        // prescaler may sit above a smaller limit and must wrap first
        repeat (64) @(posedge clock);
        len = build(f, b0, v0);
        void'(build(f, b1, v1));
        frameBits = len - int'(f[3]);
        bitLen = 16 << (2 * f[1:0]);
        scb_remote_model_i.capQ.delete();
        scb_remote_model_i.startQ.delete();
        wr(3'h3, b0);
        wr(3'h4, 8'h7F);
        wait_flag(7);
        wr(3'h3, b1);
        wr(3'h4, 8'h7F);
        for (int k = 0; k < 30 * bitLen && scb_remote_model_i.capQ.size() < 2; k++)
            @(posedge clock);
        check("frames", scb_remote_model_i.capQ.size(), 2);
        if (scb_remote_model_i.capQ.size() == 2) begin
            check("first frame", scb_remote_model_i.capQ[0], v0);
            check("second frame", scb_remote_model_i.capQ[1], v1);
            p = scb_remote_model_i.startQ[1] - scb_remote_model_i.startQ[0] - len * bitLen;
            // first start bit ends on a free-running tick, so it may be up to one tick short
            check("frame spacing", p <= 0 && p > -(int'(bitLen) / 16), 1);
        end
        repeat (2 * bitLen) @(posedge clock);
    endtask

    task automatic sync_mode;
        // receiver off: its free-running sync clock would add edges
        wr(3'h2, 8'h20);
        wr(3'h0, 8'h80);
        #1 scb_remote_model_i.syncCount = 0;
        wr(3'h3, 8'h96);
        wr(3'h4, 8'h7F);
        repeat (8 * 16 + 40) @(posedge clock);
        check("sync data", scb_remote_model_i.syncBits, 8'h96);
        check("sync bits", scb_remote_model_i.syncCount, 8);
    endtask

    initial begin
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        reset_values();
        rx_double();
        rx_parity();
        for (int i = 0; i < 11; i++)
            tx_pair(fmts[i], 8'hA5 ^ 8'(i), 8'h3C + 8'(i));
        sync_mode();
        complete_run();
    end

    // slowest case is two frames at 1024 cycles a bit; whole run near 35,000 cycles
    initial begin
        repeat (60000) @(posedge clock);
        n_errors++;
        complete_run();
    end
endmodule

`default_nettype wire
